// ==== hdl/adc_ctrl_pkg.sv ====
// constants for the converter control block
package adc_ctrl_pkg;
   // register byte addresses (word aligned)
   localparam logic [4:0] OFF_CONTROL = 5'h00;
   localparam logic [4:0] OFF_SETUP = 5'h04;
   localparam logic [4:0] OFF_RESULT_LOW = 5'h08;
   localparam logic [4:0] OFF_RESULT_HIGH = 5'h0C;
   localparam logic [4:0] OFF_PIN_SHARE = 5'h10;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] SETUP_RESET = 8'h00;
   localparam logic [11:0] PIN_SHARE_RESET = 12'h000;
   // converter_control fields
   localparam int START_BIT = 7;
   localparam int BUSY_BIT = 6;
   localparam int ENABLE_BIT = 5;
   localparam int FORMAT_BIT = 4;
   localparam int CHAN_LSB = 0;
   // converter_setup fields
   localparam int SRC_LSB = 5;
   localparam int REF_LSB = 3;
   localparam int DIV_LSB = 0;
   // codes
   localparam logic [2:0] SRC_EXTERNAL = 3'h0;
   localparam logic [2:0] SRC_BANDGAP = 3'h1;
   localparam logic [2:0] SRC_EXT_HIGH = 3'h5;
   localparam logic [1:0] REF_SUPPLY = 2'h1;
   localparam logic [3:0] CHAN_LAST = 4'hB;
   localparam int CHANNELS = 12;
   // timing in conversion-clock cycles
   localparam logic [4:0] SAMPLE_CYCLES = 5'h04;
   localparam logic [4:0] CONVERT_CYCLES = 5'h0C;
   localparam logic [4:0] TOTAL_CYCLES = 5'h10;
   typedef enum logic [1:0]
   {
      IDLE = 2'b00,
      SAMPLE = 2'b01,
      CONVERT = 2'b10
   } conv_state_type;
endpackage

// ==== hdl/conv_clock_divider.sv ====
// conversion clock tick generator, divide by two to the code
`timescale 1ns/10ps
module conv_clock_divider
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   input wire logic run,
   input wire logic [2:0] code,
   // tick out
   output logic tick
);
   logic [6:0] count;
   wire [6:0] limit = 7'((8'h01 << code) - 8'h01);
   wire wrap = (count >= limit);
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         count <= 7'h00;
      else if (!run)
         count <= 7'h00;
      else if (wrap)
         count <= 7'h00;
      else
         count <= 7'(count + 7'h01);
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         tick <= 1'b0;
      else
         tick <= run && wrap;
   end
endmodule

// ==== hdl/adc_conversion_control.sv ====
// converter control: registers, start sequencing, timing, result, pin overrides
//
// Behaviour
// - source code 001 routes bandgap; 010-100 reserved; 000 and 101-111 external.
// - reference from supply only for code 01, else external reference pin.
// - conversion clock is system clock divided by 1 through 128 per code.
// - conversion starts after start bit written high then low.
// - start bit high without return low starts nothing.
// - busy flag set once conversion starts, held during conversion.
// - busy flag cleared when conversion completes.
// - completion sets converter interrupt request flag.
// - conversion is 4 sampling plus 12 converting clock cycles, 16 total.
// - pull-high resistors removed from pins assigned to analog inputs.
// - analog pins lose other functions and port direction is overridden.
// - both result bytes cleared while enable is low.
// - format bit places 12-bit result left or right justified.
// - channel codes 0-11 connect inputs; 11xx leaves input floating.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
module adc_conversion_control
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // avalon-mm slave
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // analog core
   input wire logic [11:0] coreResult,
   output logic corePowerOn,
   output logic coreSample,
   output logic coreConvert,
   output logic [11:0] channelConnect,
   output logic bandgapConnect,
   output logic referenceFromSupply,
   // interrupt request
   output logic conversionDone,
   // pin sharing
   output logic [11:0] pullHighDisable,
   output logic [11:0] otherFunctionDisable,
   output logic [11:0] directionOverride
);
   logic [7:0] converterControl;
   logic [7:0] converterSetup;
   logic [11:0] pinShare;
   logic busy;
   logic startPrev;
   logic [7:0] resultLow;
   logic [7:0] resultHigh;
   conv_state_type state;
   logic [4:0] cycleCount;
   logic tick;
   logic answered;

   // decode: one wait cycle per access, then answer
   wire request = (read || write) && !answered;
   wire selControl = (address[4:2] == OFF_CONTROL[4:2]);
   wire selSetup = (address[4:2] == OFF_SETUP[4:2]);
   wire selLow = (address[4:2] == OFF_RESULT_LOW[4:2]);
   wire selHigh = (address[4:2] == OFF_RESULT_HIGH[4:2]);
   wire selPins = (address[4:2] == OFF_PIN_SHARE[4:2]);
   wire doWrite = write && answered;
   wire wrControl = doWrite && selControl && byteenable[0];
   wire wrSetup = doWrite && selSetup && byteenable[0];
   wire [11:0] next_pinShare =
      {byteenable[1] ? writedata[11:8] : pinShare[11:8], byteenable[0] ? writedata[7:0] : pinShare[7:0]};

   wire enable = converterControl[ENABLE_BIT];
   wire startBit = converterControl[START_BIT];
   wire formatRight = converterControl[FORMAT_BIT];
   wire [3:0] channel = converterControl[CHAN_LSB +: 4];
   wire [2:0] source = converterSetup[SRC_LSB +: 3];
   wire [1:0] reference = converterSetup[REF_LSB +: 2];
   wire [2:0] divider = converterSetup[DIV_LSB +: 3];

   // start fires on the high-to-low of the stored bit, not on the write
   wire startFall = startPrev && !startBit;
   wire launch = startFall && enable && !busy;
   wire lastTick = tick && (state == CONVERT) && (cycleCount == TOTAL_CYCLES - 5'h01);
   wire sourceExternal = (source == SRC_EXTERNAL) || (source >= SRC_EXT_HIGH);
   wire sourceBandgap = (source == SRC_BANDGAP);

   function automatic logic [15:0] pack_result(input logic right, input logic [11:0] value);
      pack_result = right ? {4'h0, value} : {value, 4'h0};
   endfunction
   wire [15:0] resultPacked = pack_result(formatRight, coreResult);

   conv_clock_divider divide
   (
      .clk(clk),
      .reset(reset),
      .run(enable && busy),
      .code(divider),
      .tick(tick)
   );

   // bus handshake
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         answered <= 1'b0;
      else
         answered <= request;
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         waitrequest <= 1'b1;
      else
         waitrequest <= !request;
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         readdata <= 32'h0000_0000;
      else if (read && request)
      begin
         if (selControl)
            readdata <= {24'h00_0000, converterControl[7], busy, converterControl[5:0]};
         else if (selSetup)
            readdata <= {24'h00_0000, converterSetup};
         else if (selLow)
            readdata <= {24'h00_0000, resultLow};
         else if (selHigh)
            readdata <= {24'h00_0000, resultHigh};
         else if (selPins)
            readdata <= {20'h0_0000, pinShare};
         else
            readdata <= 32'h0000_0000;
      end
   end

   // registers; busy bit ignores writes
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         converterControl <= CONTROL_RESET;
      else if (wrControl)
         converterControl <= {writedata[7], 1'b0, writedata[5:0]};
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         converterSetup <= SETUP_RESET;
      else if (wrSetup)
         converterSetup <= writedata[7:0];
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         pinShare <= PIN_SHARE_RESET;
      else if (doWrite && selPins)
         pinShare <= next_pinShare;
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         startPrev <= 1'b0;
      else
         startPrev <= startBit;
   end

   // sequencer
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state <= IDLE;
         cycleCount <= 5'h00;
      end
      else if (!enable)
      begin
         state <= IDLE;
         cycleCount <= 5'h00;
      end
      else
      begin
         case (state)
            IDLE:
            begin
               cycleCount <= 5'h00;
               if (launch)
                  state <= SAMPLE;
            end
            SAMPLE:
               if (tick)
               begin
                  cycleCount <= 5'(cycleCount + 5'h01);
                  if (cycleCount == SAMPLE_CYCLES - 5'h01)
                     state <= CONVERT;
               end
            CONVERT:
               if (tick)
               begin
                  cycleCount <= 5'(cycleCount + 5'h01);
                  if (lastTick)
                     state <= IDLE;
               end
            default:
               state <= IDLE;
         endcase
      end
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         busy <= 1'b0;
      else if (!enable || lastTick)
         busy <= 1'b0;
      else if (launch)
         busy <= 1'b1;
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         conversionDone <= 1'b0;
      else
         conversionDone <= lastTick && enable;
   end

   // result registers
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         resultLow <= 8'h00;
         resultHigh <= 8'h00;
      end
      else if (!enable)
      begin
         resultLow <= 8'h00;
         resultHigh <= 8'h00;
      end
      else if (lastTick)
      begin
         resultLow <= resultPacked[7:0];
         resultHigh <= resultPacked[15:8];
      end
   end

   // analog routing, registered so every output is a flop
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         corePowerOn <= 1'b0;
         coreSample <= 1'b0;
         coreConvert <= 1'b0;
         bandgapConnect <= 1'b0;
         referenceFromSupply <= 1'b0;
      end
      else
      begin
         corePowerOn <= enable;
         coreSample <= (state == SAMPLE);
         coreConvert <= (state == CONVERT);
         bandgapConnect <= enable && sourceBandgap;
         referenceFromSupply <= (reference == REF_SUPPLY);
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++)
      begin : route
         // 11xx never matches; reserved source codes connect nothing
         always_ff @(posedge clk or posedge reset)
         begin
            if (reset)
               channelConnect[ch] <= 1'b0;
            else
               channelConnect[ch] <= enable && sourceExternal && (channel == 4'(ch));
         end
         always_ff @(posedge clk or posedge reset)
         begin
            if (reset)
            begin
               pullHighDisable[ch] <= 1'b0;
               otherFunctionDisable[ch] <= 1'b0;
               directionOverride[ch] <= 1'b0;
            end
            else
            begin
               pullHighDisable[ch] <= pinShare[ch];
               otherFunctionDisable[ch] <= pinShare[ch];
               directionOverride[ch] <= pinShare[ch];
            end
         end
      end
   endgenerate
endmodule

// ==== bench/adc_control_properties.sv ====
// port assertions for the converter control block
`timescale 1ns/10ps
module adc_control_properties
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // bus
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   // core and pins
   input wire logic coreSample,
   input wire logic coreConvert,
   input wire logic [11:0] channelConnect,
   input wire logic bandgapConnect,
   input wire logic corePowerOn,
   input wire logic conversionDone,
   input wire logic [11:0] pullHighDisable,
   input wire logic [11:0] otherFunctionDisable,
   input wire logic [11:0] directionOverride
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   sequence seq_request;
      (read || write) && waitrequest;
   endsequence
   sequence seq_answer;
      !waitrequest ##1 waitrequest;
   endsequence
   a_bus_answer: assert property (seq_request |=> seq_answer) else $error("bus answer not one cycle");
   a_done_single: assert property (conversionDone |=> !conversionDone) else $error("done not a pulse");
   a_done_cause: assert property (conversionDone |-> $past(coreConvert) || $past(coreConvert, 2))
      else $error("done without conversion phase");
   a_sample_first: assert property ($rose(coreConvert) |-> $past(coreSample)) else $error("convert before sample");
   a_phase_excl: assert property (!(coreSample && coreConvert)) else $error("phases overlap");
   a_source_excl: assert property (bandgapConnect |-> channelConnect == 12'h000) else $error("pin and bandgap both on");
   a_chan_onehot: assert property ($onehot0(channelConnect)) else $error("several channels on");
   a_conn_power: assert property (bandgapConnect || channelConnect != 12'h000 |-> corePowerOn)
      else $error("input connected while off");
   a_pin_override: assert property (pullHighDisable == otherFunctionDisable && directionOverride == pullHighDisable)
      else $error("pin overrides differ");
endmodule

// ==== bench/analog_core_model.sv ====
// analog core stand-in: offers a level while converting
`timescale 1ns/10ps
module analog_core_model
(
   // converter side
   input wire logic coreConvert,
   input wire logic [11:0] level,
   output logic [11:0] coreResult
);
   // not held outside the conversion phase, so show the inverse there
   assign coreResult = coreConvert ? level : ~level;
endmodule

// ==== bench/test_adc_conversion_control.sv ====
// self-checking bench for the converter control block
`timescale 1ns/10ps
module test_adc_conversion_control
   import adc_ctrl_pkg::*;
;
   logic clk, reset, read, write, waitrequest, corePowerOn, coreSample, coreConvert;
   logic bandgapConnect, referenceFromSupply, conversionDone;
   logic [4:0] address;
   logic [3:0] byteenable;
   logic [31:0] writedata, readdata, q;
   logic [11:0] coreResult, channelConnect, pullHighDisable, otherFunctionDisable, directionOverride, level, p;
   int mismatches, checked, cyc, doneAt, doneCount, t0, n, src, ch, v;
   int sampleCount, convertCount, s0, c0, sh;
   int seed = 32'h81ae_1728;
   int expq[$];
   adc_conversion_control DUT (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .coreResult(coreResult), .corePowerOn(corePowerOn), .coreSample(coreSample), .coreConvert(coreConvert),
      .channelConnect(channelConnect), .bandgapConnect(bandgapConnect), .referenceFromSupply(referenceFromSupply),
      .conversionDone(conversionDone), .pullHighDisable(pullHighDisable),
      .otherFunctionDisable(otherFunctionDisable), .directionOverride(directionOverride));
   analog_core_model core (.coreConvert(coreConvert), .level(level), .coreResult(coreResult));
   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      sampleCount <= sampleCount + (coreSample === 1'b1);
      convertCount <= convertCount + (coreConvert === 1'b1);
      if (conversionDone === 1'b1)
      begin
         doneAt <= cyc;
         doneCount <= doneCount + 1;
      end
   end
   task automatic results();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // held until waitrequest is sampled low, one idle edge after release; only the watchdog ends a wait
   task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
      address <= a;
      read <= !w;
      write <= w;
      writedata <= d;
      @(posedge clk);
      while (waitrequest !== 1'b0)
         @(posedge clk);
      q = readdata;
      read <= 0;
      write <= 0;
      @(posedge clk);
   endtask
   function automatic int model(int x, int fmt, int hi);
      if (fmt != 0)
         return hi != 0 ? x >> 8 : x & 255;
      return hi != 0 ? x >> 4 : (x & 15) << 4;
   endfunction
   initial
   begin
      repeat (40000) @(posedge clk);
      mismatches++;
      results();
   end
   initial
   begin
      {reset, read, write, address, writedata, level} = 0;
      reset = 1;
      byteenable = 4'hF;
      repeat (6) @(posedge clk);
      reset <= 0;
      for (n = 0; n < 24; n += 4)
      begin
         bus(n[4:0], 0, 0);
         chk("reset value", 0, q);
      end
      p = 12'($random(seed));
      bus(5'h10, 1, {20'h0_0000, p});
      repeat (2) @(posedge clk);
      chk("pin overrides", {p, p, p}, {pullHighDisable, otherFunctionDisable, directionOverride});
      bus(5'h10, 1, 32'h0000_0FFF);
      repeat (2) @(posedge clk);
      chk("pins analog", 12'hFFF, pullHighDisable);
      for (n = 0; n < 4; n++)
      begin
         bus(5'h04, 1, n << REF_LSB);
         repeat (2) @(posedge clk);
         chk("reference", n == 1, referenceFromSupply);
      end
      for (src = 0; src < 8; src++)
      begin
         ch = src == 1 ? 12 : $random(seed) & 15;
         // leave the internal source before opening a pin, enter it only after closing them
         if (src != 1)
            bus(5'h04, 1, src << SRC_LSB);
         bus(5'h00, 1, 32'h20 | ch);
         if (src == 1)
            bus(5'h04, 1, src << SRC_LSB);
         repeat (2) @(posedge clk);
         v = (src == 0 || src > 4) && ch < 12 ? 1 << ch : 0;
         chk("channel", v, channelConnect);
         chk("bandgap", src == 1, bandgapConnect);
      end
      for (n = 0; n < 16; n++)
      begin
         sh = n >> 1;
         level <= 12'($random(seed));
         bus(5'h04, 1, n >> 1);
         bus(5'h00, 1, 32'h20 | (n & 1) << FORMAT_BIT);
         repeat (4) @(posedge clk);
         bus(5'h00, 1, 32'hA0 | (n & 1) << FORMAT_BIT);
         repeat (40) @(posedge clk);
         bus(5'h00, 0, 0);
         chk("busy on start high", 0, q[BUSY_BIT]);
         chk("done count", n, doneCount);
         t0 = cyc;
         s0 = sampleCount;
         c0 = convertCount;
         expq.push_back(level);
         bus(5'h00, 1, 32'h20 | (n & 1) << FORMAT_BIT);
         bus(5'h00, 0, 0);
         chk("busy set", 1, q[BUSY_BIT]);
         chk("power on", 1, corePowerOn);
         v = 0;
         do
         begin
            bus(5'h00, 0, 0);
            v++;
         end while (q[BUSY_BIT] === 1'b1 && v < 1000);
         chk("busy clear", 0, q[BUSY_BIT]);
         chk("done count", n + 1, doneCount);
         v = doneAt - t0;
         chk("duration", 1, v >= 16 << sh && v <= (17 << sh) + 6);
         chk("convert cycles", 12 << sh, convertCount - c0);
         v = sampleCount - s0;
         chk("sample cycles", 1, v >= 4 << sh && v <= (4 << sh) + 2);
         v = expq.pop_front();
         bus(5'h08, 0, 0);
         chk("result low", model(v, n & 1, 0), q);
         bus(5'h0C, 0, 0);
         chk("result high", model(v, n & 1, 1), q);
      end
      bus(5'h00, 1, 0);
      bus(5'h0C, 0, 0);
      chk("cleared high", 0, q);
      chk("power off", 0, corePowerOn);
      chk("channel off", 0, channelConnect);
      results();
   end
endmodule
bind adc_conversion_control adc_control_properties checker_inst (.clk(clk), .reset(reset), .read(read),
   .write(write), .waitrequest(waitrequest), .coreSample(coreSample), .coreConvert(coreConvert),
   .channelConnect(channelConnect), .bandgapConnect(bandgapConnect), .corePowerOn(corePowerOn),
   .conversionDone(conversionDone), .pullHighDisable(pullHighDisable),
   .otherFunctionDisable(otherFunctionDisable), .directionOverride(directionOverride));
